// ===== src/tp_mapper.sv
// two-port optical teleprotection to n x 64k tdm slot mapper with axi4-lite registers
//
// Notes on behaviour
// - two independent full-duplex ports, each n times 64 kbps synchronous.
// - standby port uses no slots; only active ports insert and extract.
// - port data goes only to one of eight wan link positions.
// - one to twelve slots on a single link form one circuit.
// - slots 1..24 on t1 links, 1..31 on e1 links.
// - slot 16 refused on e1 links carrying signalling.
// - slot sets must be contiguous; others are rejected.
// - every slot carries a fixed 64 kbps; rate not configurable.
// - ports always run in multiplexer role.
// - transmit timing always from the internal system clock.
// - user loopback returns equipment data back to the same equipment.
// - during user loopback far-end wan data is not forwarded locally.
// - network loopback reinserts extracted wan slot data toward far end.
// - loopback is off, user or network; off after reset.
// - alarm shows normal when the optical link is fault free.
// - alarm shows yellow when remote equipment reports a receive fault and no local receive fault is detected.
// - alarm shows red when local optical receive fault is detected.
// - each port is in standby after reset.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

module tp_mapper
    import tp_mapper_pkg::*;
#(
    parameter int NPORTS = 2
) (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]                    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]                    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // teleprotection_equipment side, one lane per port
    input  wire logic [NPORTS-1:0][7:0]        eq_rx_data,
    input  wire logic [NPORTS-1:0]             eq_rx_valid,
    output logic      [NPORTS-1:0]             eq_rx_req,
    output logic      [NPORTS-1:0][7:0]        eq_tx_data,
    output logic      [NPORTS-1:0]             eq_tx_valid,
    // optical fault pins, asynchronous
    input  wire logic [NPORTS-1:0]             rx_fault_pin,
    input  wire logic [NPORTS-1:0]             remote_fault_pin,
    // wan tdm backplane
    input  wire tp_mapper_pkg::tdm_slot_t      wan_rx,
    input  wire logic                          wan_rx_strobe,
    output logic [7:0]                         wan_tx_data,
    output logic                               wan_tx_en,
    // alarms and interrupt
    output logic [NPORTS-1:0][1:0]             alarm,
    output logic                               irq
);

    // the register map is laid out for exactly two ports
    if (NPORTS != 2) begin : g_bad_ports
        $error("tp_mapper serves exactly two ports");
    end

    // ---- register state
    port_cfg_t  [NPORTS-1:0]       cfg_q;
    logic       [NPORTS-1:0][31:0] slots_q;
    logic       [15:0]             link_cfg_q;
    logic       [IRQ_BITS-1:0]     irq_stat_q;
    logic       [IRQ_BITS-1:0]     irq_mask_q;
    logic       [NPORTS-1:0]       reject_pulse;

    // ---- axi write channel state
    logic                          aw_held_q;
    logic                          w_held_q;
    logic       [7:0]              aw_addr_q;
    logic       [31:0]             w_data_q;
    logic       [3:0]              w_strb_q;
    logic                          wr_fire;
    logic       [31:0]             wr_old;
    logic       [31:0]             wr_val;
    logic                          wr_hit;

    // byte lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        for (int b = 0; b < 4; b++) begin
            r[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
        return r;
    endfunction : merge

    // slot map check against the target link's framing
    function automatic logic slots_ok(input logic [31:0] m, input logic e1, input logic sig);
        logic [31:0] low;
        logic [5:0]  cnt;
        logic        ok;
        low = m & (~m + 32'h0000_0001);
        cnt = 6'h00;
        for (int i = 0; i < 32; i++) begin
            cnt = cnt + {5'h00, m[i]};
        end
        // contiguity: adding the lowest bit clears the whole run
        ok = (((m + low) & m) == 32'h0000_0000);
        ok = ok && (cnt <= 6'(MAX_SLOTS)) && !m[0];
        if (!e1) begin
            ok = ok && ((m >> (T1_LAST_SLOT + 1)) == 32'h0000_0000);
        end else if (sig) begin
            ok = ok && !m[E1_SIG_SLOT];
        end
        return ok;
    endfunction : slots_ok

    // both halves of a write must be in hand before it acts
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    // current value of the addressed writable register, zero at the alarm and both irq offsets
    always_comb begin
        wr_old = 32'h0000_0000;
        wr_hit = 1'b1;
        if (aw_addr_q == OFF_P0_CTRL) begin
            wr_old = {26'h0, cfg_q[0]};
        end else if (aw_addr_q == OFF_P0_SLOTS) begin
            wr_old = slots_q[0];
        end else if (aw_addr_q == OFF_P1_CTRL) begin
            wr_old = {26'h0, cfg_q[1]};
        end else if (aw_addr_q == OFF_P1_SLOTS) begin
            wr_old = slots_q[1];
        end else if (aw_addr_q >= OFF_ALARMS && aw_addr_q <= OFF_IRQ_MASK) begin
            wr_old = 32'h0000_0000;
        end else if (aw_addr_q == OFF_LINK_CFG) begin
            wr_old = {16'h0000, link_cfg_q};
        end else begin
            wr_hit = 1'b0;
        end
        wr_val = merge(wr_old, w_data_q, w_strb_q);
    end

    // address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_held_q, w_held_q, s_axi_awready, s_axi_wready, s_axi_bvalid} <= '0;
            {aw_addr_q, w_data_q, w_strb_q} <= '0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready;
            s_axi_wready  <= !w_held_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // port configuration and slot maps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < NPORTS; p++) begin
                cfg_q[p].active             <= 1'b0;
                cfg_q[p].loopback_select    <= LB_OFF;
                cfg_q[p].destination_select <= 3'h0;
                slots_q[p]                  <= RST_SLOTS;
            end
            link_cfg_q   <= RST_LINK_CFG;
            irq_mask_q   <= '0;
            reject_pulse <= '0;
        end else begin
            reject_pulse <= '0;
            if (wr_fire) begin
                for (int p = 0; p < NPORTS; p++) begin
                    if (aw_addr_q == (p == 0 ? OFF_P0_CTRL : OFF_P1_CTRL)) begin
                        cfg_q[p].active <= wr_val[CTRL_ACTIVE_BIT];
                        // three values, the spare code falls back to off
                        cfg_q[p].loopback_select <= (wr_val[CTRL_LB_LSB +: 2] == 2'b11) ?
                            LB_OFF : loopback_select_t'(wr_val[CTRL_LB_LSB +: 2]);
                        cfg_q[p].destination_select <= wr_val[CTRL_DEST_LSB +: 3];
                    end
                    if (aw_addr_q == (p == 0 ? OFF_P0_SLOTS : OFF_P1_SLOTS)) begin
                        if (slots_ok(wr_val,
                                     link_cfg_q[2*cfg_q[p].destination_select + LINK_E1_OFS],
                                     link_cfg_q[2*cfg_q[p].destination_select + LINK_SIG_OFS]))
                        begin
                            slots_q[p] <= wr_val;
                        end else begin
                            reject_pulse[p] <= 1'b1;
                        end
                    end
                end
                if (aw_addr_q == OFF_LINK_CFG) begin
                    link_cfg_q <= wr_val[15:0];
                end
                if (aw_addr_q == OFF_IRQ_MASK) begin
                    irq_mask_q <= wr_val[IRQ_BITS-1:0];
                end
            end
        end
    end

    // ---- read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= '0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                if (s_axi_araddr[7:2] == OFF_P0_CTRL[7:2]) begin
                    // fixed mux role and internal clock read as one
                    s_axi_rdata <= {22'h0, 1'b1, 1'b1, 2'b00, cfg_q[0]};
                end else if (s_axi_araddr[7:2] == OFF_P0_SLOTS[7:2]) begin
                    s_axi_rdata <= slots_q[0];
                end else if (s_axi_araddr[7:2] == OFF_P1_CTRL[7:2]) begin
                    s_axi_rdata <= {22'h0, 1'b1, 1'b1, 2'b00, cfg_q[1]};
                end else if (s_axi_araddr[7:2] == OFF_P1_SLOTS[7:2]) begin
                    s_axi_rdata <= slots_q[1];
                end else if (s_axi_araddr[7:2] == OFF_ALARMS[7:2]) begin
                    s_axi_rdata <= {28'h0, alarm[1], alarm[0]};
                end else if (s_axi_araddr[7:2] == OFF_IRQ_STAT[7:2]) begin
                    s_axi_rdata <= {26'h0, irq_stat_q};
                end else if (s_axi_araddr[7:2] == OFF_IRQ_MASK[7:2]) begin
                    s_axi_rdata <= {26'h0, irq_mask_q};
                end else if (s_axi_araddr[7:2] == OFF_LINK_CFG[7:2]) begin
                    s_axi_rdata <= {16'h0000, link_cfg_q};
                end else begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---- fault pin synchronisers, three stages each
    logic [NPORTS-1:0] los_s1, los_s2, los_s3, los_q;
    logic [NPORTS-1:0] rem_s1, rem_s2, rem_s3, rem_q;
    // a level change counts only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {los_s1, los_s2, los_s3, los_q, rem_s1, rem_s2, rem_s3, rem_q} <= '0;
        end else begin
            los_s1 <= rx_fault_pin;
            los_s2 <= los_s1;
            los_s3 <= los_s2;
            rem_s1 <= remote_fault_pin;
            rem_s2 <= rem_s1;
            rem_s3 <= rem_s2;
            for (int p = 0; p < NPORTS; p++) begin
                if (los_s2[p] == los_s3[p]) begin
                    los_q[p] <= los_s3[p];
                end
                if (rem_s2[p] == rem_s3[p]) begin
                    rem_q[p] <= rem_s3[p];
                end
            end
        end
    end

    // alarm state, red outranks yellow since a local fault hides the remote report
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm <= '0;
        end else begin
            for (int p = 0; p < NPORTS; p++) begin
                if (los_q[p]) begin
                    alarm[p] <= ALM_RED;
                end else if (rem_q[p]) begin
                    alarm[p] <= ALM_YEL;
                end else begin
                    alarm[p] <= ALM_NORM;
                end
            end
        end
    end

    // sticky events, a new event wins over a same-cycle clear
    logic [IRQ_BITS-1:0] irq_set;
    always_comb begin
        irq_set = '0;
        for (int p = 0; p < NPORTS; p++) begin
            irq_set[IRQ_RED_LSB + p] = los_q[p] && alarm[p] != ALM_RED;
            irq_set[IRQ_YEL_LSB + p] = !los_q[p] && rem_q[p] && alarm[p] != ALM_YEL;
            irq_set[IRQ_REJ_LSB + p] = reject_pulse[p];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr_fire && aw_addr_q == OFF_IRQ_STAT) ?
                          wr_val[IRQ_BITS-1:0] : '0)) | irq_set;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ---- slot match per port on the current backplane slot
    logic [NPORTS-1:0] hit;
    always_comb begin
        for (int p = 0; p < NPORTS; p++) begin
            hit[p] = wan_rx_strobe && cfg_q[p].active
                     && wan_rx.link == cfg_q[p].destination_select
                     && slots_q[p][wan_rx.slot];
        end
    end

    // one held byte per port; the request pulse paces the equipment from our clock
    logic [NPORTS-1:0][7:0] hold_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q    <= '{default: IDLE_BYTE};
            eq_rx_req <= '0;
        end else begin
            for (int p = 0; p < NPORTS; p++) begin
                if (eq_rx_valid[p]) begin
                    hold_q[p] <= eq_rx_data[p];
                end
                // timing from the internal clock, one byte per claimed slot
                eq_rx_req[p] <= hit[p];
            end
        end
    end

    // wan insertion; port 0 wins if software overlaps the two maps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wan_tx_data <= IDLE_BYTE;
            wan_tx_en   <= 1'b0;
        end else begin
            wan_tx_en <= |hit;
            for (int p = NPORTS - 1; p >= 0; p--) begin
                if (hit[p]) begin
                    // net loop returns the wan byte, else held bytes in slot order
                    wan_tx_data <= (cfg_q[p].loopback_select == LB_NET) ? wan_rx.data
                                                                        : hold_q[p];
                end
            end
        end
    end

    // toward the equipment: wan bytes, or its own bytes in user loopback
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eq_tx_data  <= '{default: IDLE_BYTE};
            eq_tx_valid <= '0;
        end else begin
            for (int p = 0; p < NPORTS; p++) begin
                eq_tx_valid[p] <= 1'b0;
                if (cfg_q[p].loopback_select == LB_USER) begin
                    // equipment data looped, far end cut off
                    eq_tx_data[p]  <= eq_rx_data[p];
                    eq_tx_valid[p] <= eq_rx_valid[p];
                end else if (hit[p] && cfg_q[p].loopback_select == LB_OFF) begin
                    // one 64k byte per slot, ascending order
                    eq_tx_data[p]  <= wan_rx.data;
                    eq_tx_valid[p] <= 1'b1;
                end
            end
        end
    end

endmodule : tp_mapper

// ===== src/tp_mapper_pkg.sv
// shared constants, register map and carrier types of the teleprotection tdm mapper
package tp_mapper_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_P0_CTRL   = 8'h00;
    localparam logic [7:0] OFF_P0_SLOTS  = 8'h04;
    localparam logic [7:0] OFF_P1_CTRL   = 8'h08;
    localparam logic [7:0] OFF_P1_SLOTS  = 8'h0c;
    localparam logic [7:0] OFF_ALARMS    = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h18;
    localparam logic [7:0] OFF_LINK_CFG  = 8'h1c;

    // control register fields
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam int CTRL_LB_LSB     = 1;
    localparam int CTRL_DEST_LSB   = 3;
    localparam int CTRL_MUX_BIT    = 8;
    localparam int CTRL_INTCLK_BIT = 9;

    // link config: bit 2k = e1 framing, bit 2k+1 = e1 signalling, for position k
    localparam int LINK_E1_OFS  = 0;
    localparam int LINK_SIG_OFS = 1;

    // slot figures
    localparam int MAX_SLOTS    = 12;
    localparam int T1_LAST_SLOT = 24;
    localparam int E1_SIG_SLOT  = 16;
    localparam int NUM_LINKS    = 8;

    // irq status fields: red, yellow, rejected slot map, each one bit per port
    localparam int IRQ_RED_LSB = 0;
    localparam int IRQ_YEL_LSB = 2;
    localparam int IRQ_REJ_LSB = 4;
    localparam int IRQ_BITS    = 6;

    // reset values
    localparam logic [31:0] RST_SLOTS    = 32'h0000_0000;
    localparam logic [15:0] RST_LINK_CFG = 16'h0000;
    localparam logic [7:0]  IDLE_BYTE    = 8'hff;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {LB_OFF, LB_USER, LB_NET} loopback_select_t;
    typedef enum logic [1:0] {ALM_NORM, ALM_YEL, ALM_RED} alarm_t;

    // per port configuration
    typedef struct packed {
        logic [2:0]       destination_select;
        loopback_select_t loopback_select;
        logic             active;
    } port_cfg_t;

    // one tdm slot as seen on the backplane
    typedef struct packed {
        logic [2:0] link;
        logic [4:0] slot;
        logic [7:0] data;
    } tdm_slot_t;

endpackage : tp_mapper_pkg

// ===== sim/tp_equip_model.sv
// teleprotection equipment model for one port lane
`timescale 1ns/10ps
module tp_equip_model #(
    parameter logic [7:0] BASE = 8'h40
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // byte lane toward the mapper
    input  wire logic       req,
    output logic [7:0]      data,
    output logic            valid
);
    logic [7:0] cnt_q;
    logic       first_q;
    // one fresh byte per slot request, first byte after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 8'h00;
            first_q <= 1'b1;
            valid <= 1'b0;
            data <= 8'h00;
        end else if (first_q || req) begin
            valid <= 1'b1;
            data <= BASE + cnt_q;
            cnt_q <= cnt_q + 8'h01;
            first_q <= 1'b0;
        end else begin
            // idle lane toggles; a stale byte never looks valid
            valid <= 1'b0;
            data <= ~data;
        end
    end
endmodule : tp_equip_model

// ===== sim/tp_mapper_chk.sv
// port level assertions for the teleprotection slot mapper
`timescale 1ns/10ps
module tp_mapper_chk
    import tp_mapper_pkg::*;
#(
    parameter int NPORTS = 2
) (
    // clock and reset
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // register bus answers
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic [31:0]            s_axi_rdata,
    // datapath and alarms
    input wire logic                   wan_rx_strobe,
    input wire logic                   wan_tx_en,
    input wire logic [NPORTS-1:0]      eq_rx_req,
    input wire logic [NPORTS-1:0]      eq_rx_valid,
    input wire logic [NPORTS-1:0]      eq_tx_valid,
    input wire logic [NPORTS-1:0]      rx_fault_pin,
    input wire logic [NPORTS-1:0]      remote_fault_pin,
    input wire logic [NPORTS-1:0][1:0] alarm
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // pins held past the three-flop sync chain
    sequence red_held;
        rx_fault_pin[0] [*8];
    endsequence
    sequence yel_held;
        (!rx_fault_pin[0] && remote_fault_pin[0]) [*8];
    endsequence
    sequence quiet_held;
        (!rx_fault_pin[0] && !remote_fault_pin[0]) [*8];
    endsequence
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_txen_cause: assert property (
        wan_tx_en |-> $past(wan_rx_strobe)) else $error("slot output without strobe");
    chk_req_hit: assert property (
        |eq_rx_req |-> wan_tx_en) else $error("byte consumed without slot");
    chk_eqtx_cause: assert property (
        eq_tx_valid[0] |-> $past(wan_rx_strobe) || $past(eq_rx_valid[0]))
        else $error("equipment byte without cause");
    chk_red_alarm: assert property (
        red_held |-> alarm[0] == ALM_RED) else $error("red alarm missing");
    chk_yel_alarm: assert property (
        yel_held |-> alarm[0] == ALM_YEL) else $error("yellow alarm missing");
    chk_norm_alarm: assert property (
        quiet_held |-> alarm[0] == ALM_NORM) else $error("normal status missing");
endmodule : tp_mapper_chk
bind tp_mapper tp_mapper_chk #(.NPORTS(NPORTS)) i_chk (.*);

// ===== sim/tb.sv
// self-checking bench for the teleprotection slot mapper
`timescale 1ns/10ps
module tb;
    import tp_mapper_pkg::*;
    logic aclk = 0, aresetn = 0, irq, wan_tx_en, wan_rx_strobe = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, wan_tx_data, nb = 8'h40, m_d;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, o_en, o_v, m_v;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, eq_rx_req, eq_tx_valid, rx_fault_pin = 0;
    logic [1:0] remote_fault_pin = 0;
    logic [1:0][7:0] eq_tx_data;
    logic [1:0][1:0] alarm;
    wire [1:0][7:0] eq_rx_data;
    wire [1:0] eq_rx_valid;
    tdm_slot_t wan_rx = '0;
    int num_errors = 0, comparisons = 0;
    logic [31:0] tv [8] = '{32'h1c000, 32'ha, 32'h3ffe, 32'h1ffe, 32'h8000_0000, 32'h1,
                            32'h0200_0000, 32'h0100_0000};
    logic [7:0] rj = 8'h67;
    logic [31:0] map = 0;
    always #4 aclk = ~aclk;
    tp_mapper #(.NPORTS(2)) i_dut (.*);
    tp_equip_model #(.BASE(8'h40)) i_eq0 (.aclk, .aresetn, .req(eq_rx_req[0]),
        .data(eq_rx_data[0]), .valid(eq_rx_valid[0]));
    tp_equip_model #(.BASE(8'h80)) i_eq1 (.aclk, .aresetn, .req(eq_rx_req[1]),
        .data(eq_rx_data[1]), .valid(eq_rx_valid[1]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("counts: %0d compares, %0d mismatches", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // both halves offered together, bready held until the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (int i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 0;
                chk(s_axi_bresp, er);
                return;
            end
        end
        num_errors++;
        complete_run();
    endtask : wr
    task automatic rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (int i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 0;
                chk(s_axi_rdata, ed);
                chk(s_axi_rresp, er);
                return;
            end
        end
        num_errors++;
        complete_run();
    endtask : rdr
    // one backplane slot; answer, then mirror, watched
    task automatic slot(input logic [2:0] l, input logic [4:0] s, input logic [7:0] d);
        @(posedge aclk);
        wan_rx <= '{l, s, d};
        wan_rx_strobe <= 1;
        @(posedge aclk);
        wan_rx_strobe <= 0;
        #1;
        {o_en, o_v, m_v} = 3'b000;
        chk(wan_rx_strobe, 1'b0);
        o_en = wan_tx_en;
        o_v = eq_tx_valid[0];
        m_d = eq_tx_data[0];
        if (o_en === 1'b1) chk(wan_tx_data, nb);
        for (int i = 0; i < 3; i++) begin
            @(posedge aclk);
            #1;
            if (eq_tx_valid[0]) m_d = eq_tx_data[0];
            m_v |= eq_tx_valid[0];
        end
    endtask : slot
    task automatic t_regs;
        rdr(OFF_P0_CTRL, 32'h300, RESP_OKAY);
        wr(OFF_P0_CTRL, 32'h6, RESP_OKAY);
        rdr(OFF_P0_CTRL, 32'h300, RESP_OKAY);
        wr(8'h20, 32'h1, RESP_SLVERR);
        rdr(8'h20, 32'h0, RESP_SLVERR);
        $display("test regs done");
    endtask : t_regs
    task automatic t_slots;
        wr(OFF_LINK_CFG, 32'h3, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            if (i == 1) wr(OFF_IRQ_MASK, 32'h10, RESP_OKAY);
            if (i == 6) wr(OFF_P0_CTRL, 32'h8, RESP_OKAY);
            wr(OFF_P0_SLOTS, tv[i], RESP_OKAY);
            if (!rj[i]) map = tv[i];
            rdr(OFF_IRQ_STAT, rj[i] ? 32'h10 : 32'h0, RESP_OKAY);
            chk(irq, rj[i] && i > 0);
            rdr(OFF_P0_SLOTS, map, RESP_OKAY);
            wr(OFF_IRQ_STAT, 32'h10, RESP_OKAY);
        end
        chk(irq, 1'b0);
        $display("test slots done");
    endtask : t_slots
    task automatic t_data;
        wr(OFF_P0_SLOTS, 32'he, RESP_OKAY);
        wr(OFF_P0_CTRL, 32'h0, RESP_OKAY);
        slot(3'd0, 5'd1, 8'h11);
        chk(o_en, 1'b0);
        wr(OFF_P0_CTRL, 32'h1, RESP_OKAY);
        for (int s = 1; s < 5; s++) begin
            slot(3'd0, s[4:0], 8'h10 + s[7:0]);
            chk(o_en, s < 4);
            chk({o_v, m_d}, s < 4 ? {1'b1, 8'h10 + s[7:0]} : 9'h013);
            if (s < 4) nb++;
        end
        slot(3'd1, 5'd2, 8'h33);
        chk(o_en, 1'b0);
        $display("test data done");
    endtask : t_data
    task automatic t_loop;
        wr(OFF_P0_CTRL, 32'h3, RESP_OKAY);
        slot(3'd0, 5'd1, 8'h5a);
        nb++;
        chk({o_en, o_v}, 2'b10);
        chk({m_v, m_d}, {1'b1, nb});
        wr(OFF_P0_CTRL, 32'h5, RESP_OKAY);
        nb = 8'ha5;
        slot(3'd0, 5'd2, 8'ha5);
        chk({o_en, o_v, m_v}, 3'b100);
        $display("test loop done");
    endtask : t_loop
    task automatic t_alarm;
        wr(OFF_IRQ_MASK, 32'h3, RESP_OKAY);
        rx_fault_pin <= 2'b01;
        repeat (10) @(posedge aclk);
        chk({irq, alarm[0]}, {1'b1, ALM_RED});
        rx_fault_pin <= 2'b10;
        remote_fault_pin <= 2'b01;
        repeat (10) @(posedge aclk);
        rdr(OFF_ALARMS, 32'h9, RESP_OKAY);
        rdr(OFF_IRQ_STAT, 32'h7, RESP_OKAY);
        wr(OFF_IRQ_STAT, 32'h7, RESP_OKAY);
        {rx_fault_pin, remote_fault_pin} <= 4'h0;
        repeat (10) @(posedge aclk);
        rdr(OFF_ALARMS, 32'h0, RESP_OKAY);
        chk(irq, 1'b0);
        $display("test alarm done");
    endtask : t_alarm
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        t_regs();
        t_slots();
        t_data();
        t_loop();
        t_alarm();
        complete_run();
    end
endmodule : tb
